// File: smbus_boot_regs.svh
`ifndef SMBUS_BOOT_REGS_SVH
`define SMBUS_BOOT_REGS_SVH

// Channels and per-channel register slots
`define NUM_CHAN        4
`define CHAN_SLOTS      8

// Slave address scheme (seven-bit)
`define BASE_ADDR7      7'h18
`define TEST_ADDR7      7'h18
`define MAX_ADDR7       7'h27

// EEPROM load sequence
`define EE_DEV_W        8'hA0
`define EE_DEV_R        8'hA1
`define EE_WORD_ADDR    8'h00
`define EE_LAST_BYTE    6'h1F

// Register offsets on the two-wire bus
`define OFS_RATE        8'h2F
`define OFS_CNT0_LO     8'h60
`define OFS_CNT0_HI     8'h61
`define OFS_CNT1_LO     8'h62
`define OFS_CNT1_HI     8'h63
`define OFS_CNT_TOL     8'h64
`define OFS_SWING       8'h2D
`define OFS_DEEMPH      8'h15
`define OFS_CHAN_SEL    8'hFF

// Slot of each register inside a channel
`define SLOT_RATE       3'h0
`define SLOT_CNT0_LO    3'h1
`define SLOT_CNT0_HI    3'h2
`define SLOT_CNT1_LO    3'h3
`define SLOT_CNT1_HI    3'h4
`define SLOT_CNT_TOL    3'h5
`define SLOT_SWING      3'h6
`define SLOT_DEEMPH     3'h7

// Rate nibble selecting the dual Ethernet mode
`define RATE_AUTO_ETH   4'hF

// Bit positions in the pin synchroniser
`define SY_MODE         5
`define SY_RDN          4

// Timing
`define CLK_PERIOD_NS   25
`define SCL_PERIOD_NS   200
`define SCL_QUARTER_CYC (`SCL_PERIOD_NS / (4 * `CLK_PERIOD_NS))
`define MEAS_WINDOW_NS  51200
`define MEAS_WINDOW_CYC (`MEAS_WINDOW_NS / `CLK_PERIOD_NS)

`endif

// File: smbus_boot_pkg.sv
`include "smbus_boot_regs.svh"

package smbus_boot_pkg;

  typedef enum logic [1:0] {T_BOOT, T_WAIT, T_LOAD, T_SLAVE} top_type;
  typedef enum logic [1:0] {M_START, M_SEND, M_RECV, M_STOP} mst_type;
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_REG, S_WR, S_RD} slv_type;

  typedef struct packed {
    top_type                                 top;
    mst_type                                 mst;
    slv_type                                 slv;
    logic [5:0]                              sy1;
    logic [5:0]                              sy2;
    logic [1:0]                              ln1;
    logic [1:0]                              ln2;
    logic [1:0]                              ln3;
    logic [`NUM_CHAN-1:0]                    os1;
    logic [`NUM_CHAN-1:0]                    os2;
    logic [`NUM_CHAN-1:0]                    os3;
    logic [1:0]                              boot;
    logic                                    mode_slave;
    logic [6:0]                              addr;
    logic                                    done_n;
    logic                                    drv_lvl;
    logic                                    scl_oe;
    logic                                    sda_oe;
    logic                                    nack;
    logic [1:0]                              ph;
    logic [3:0]                              qc;
    logic [3:0]                              bitn;
    logic [2:0]                              step;
    logic [5:0]                              nbyte;
    logic [7:0]                              sh;
    logic [3:0]                              cnt;
    logic [7:0]                              ptr;
    logic [7:0]                              tx;
    logic [1:0]                              chsel;
    logic [`NUM_CHAN-1:0][`CHAN_SLOTS-1:0][7:0] regs;
    logic [15:0]                             win;
    logic [`NUM_CHAN-1:0][15:0]              fcnt;
    logic [`NUM_CHAN-1:0]                    lock_ok;
    logic [`NUM_CHAN-1:0]                    auto_eth;
  } state_type;

endpackage

// File: smbus_config_boot.sv
// Functional notes
// - In master mode, start EEPROM load only after read-enable is sampled low.
// - Drive done output low when the EEPROM load completes.
// - After the load, give up mastership and serve as a bus slave.
// - Take the bus for a load only when read-enable is seen low.
// - Sample the four address straps once at power-up and latch them.
// - Seven-bit address is 0x18 plus strap value, write addresses 0x30 to 0x4E.
// - Slave mode with read-enable not low uses fixed test address 0x18.
// - Address byte LSB selects direction: 0 write, 1 read-back.
// - After the load completes, or at once in slave mode, all registers are readable and writable over the bus.
// - Rate, swing, de-emphasis and count settings are held per channel.
// - Rate nibble 0x2F[7:4] and registers 0x60 to 0x64 are bus-writable.
// - Reject false lock by counting oscillator against reference versus expected count.
// - Rate nibble 4'b1111 selects dual Ethernet mode with automatic group choice.
`timescale 1ns/1ps
`include "smbus_boot_regs.svh"

module smbus_config_boot
  import smbus_boot_pkg::*;
#(
  parameter int MEAS_WINDOW_CYC = `MEAS_WINDOW_CYC
) (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         bus_mode_select,
  input  wire logic                         read_en_n,
  input  wire logic [3:0]                   slave_addr_strap_pins,
  input  wire logic                         two_wire_serial_clock_i,
  output logic                              two_wire_serial_clock_o,
  output logic                              two_wire_serial_clock_oe,
  input  wire logic                         serial_data_i,
  output logic                              serial_data_o,
  output logic                              serial_data_oe,
  input  wire logic [`NUM_CHAN-1:0]         recovered_clock_oscillator_div,
  output logic                              done_n,
  output logic [6:0]                        slave_addr,
  output logic [`NUM_CHAN*`CHAN_SLOTS*8-1:0] channel_config,
  output logic [`NUM_CHAN-1:0]              dual_rate_auto,
  output logic [`NUM_CHAN-1:0]              freq_lock_ok
);

  state_type            st;
  state_type            nx;
  logic [`NUM_CHAN-1:0] fmatch;
  logic                 tick;
  logic                 rise;
  logic                 fall;
  logic                 start_c;
  logic                 stop_c;

  function automatic mst_type seg_kind(input logic [2:0] s);
    case (s)
      3'h0, 3'h3:       seg_kind = M_START;
      3'h1, 3'h2, 3'h4: seg_kind = M_SEND;
      3'h5:             seg_kind = M_RECV;
      default:          seg_kind = M_STOP;
    endcase
  endfunction

  function automatic logic [7:0] seg_byte(input logic [2:0] s);
    case (s)
      3'h1:    seg_byte = `EE_DEV_W;
      3'h2:    seg_byte = `EE_WORD_ADDR;
      3'h4:    seg_byte = `EE_DEV_R;
      default: seg_byte = 8'h00;
    endcase
  endfunction

  // Valid flag and slot of a per-channel register offset
  function automatic logic [3:0] slot_of(input logic [7:0] a);
    case (a)
      `OFS_RATE:    slot_of = {1'b1, `SLOT_RATE};
      `OFS_CNT0_LO: slot_of = {1'b1, `SLOT_CNT0_LO};
      `OFS_CNT0_HI: slot_of = {1'b1, `SLOT_CNT0_HI};
      `OFS_CNT1_LO: slot_of = {1'b1, `SLOT_CNT1_LO};
      `OFS_CNT1_HI: slot_of = {1'b1, `SLOT_CNT1_HI};
      `OFS_CNT_TOL: slot_of = {1'b1, `SLOT_CNT_TOL};
      `OFS_SWING:   slot_of = {1'b1, `SLOT_SWING};
      `OFS_DEEMPH:  slot_of = {1'b1, `SLOT_DEEMPH};
      default:      slot_of = 4'h0;
    endcase
  endfunction

  function automatic logic [7:0] rd_byte(input state_type s, input logic [7:0] a);
    logic [3:0] sl;
    sl = slot_of(a);
    if (a == `OFS_CHAN_SEL) rd_byte = {6'h00, s.chsel};
    else if (sl[3]) rd_byte = s.regs[s.chsel][sl[2:0]];
    else rd_byte = 8'h00;
  endfunction

  function automatic logic near(input logic [15:0] a, input logic [15:0] b, input logic [3:0] t);
    near = ((a >= b) ? (a - b) : (b - a)) <= {12'h000, t};
  endfunction

  // Count inside window versus expected count of group 0, and of group 1 only in dual Ethernet mode
  generate
    for (genvar c = 0; c < `NUM_CHAN; c++) begin : g_chan
      assign fmatch[c] = near(st.fcnt[c], {1'b0, st.regs[c][`SLOT_CNT0_HI][6:0], st.regs[c][`SLOT_CNT0_LO]},
                              st.regs[c][`SLOT_CNT_TOL][3:0])
                       | (st.auto_eth[c] & near(st.fcnt[c],
                              {1'b0, st.regs[c][`SLOT_CNT1_HI][6:0], st.regs[c][`SLOT_CNT1_LO]},
                              st.regs[c][`SLOT_CNT_TOL][7:4]));
    end
  endgenerate

  assign tick    = (st.qc == 4'(`SCL_QUARTER_CYC - 1));
  assign rise    = st.ln2[1] & ~st.ln3[1];
  assign fall    = ~st.ln2[1] & st.ln3[1];
  assign start_c = st.ln2[1] & st.ln3[1] & ~st.ln2[0] & st.ln3[0];
  assign stop_c  = st.ln2[1] & st.ln3[1] & st.ln2[0] & ~st.ln3[0];

  always_comb begin
    logic [3:0] sl;
    sl = 4'h0;
    nx = st;
    nx.sy1 = {bus_mode_select, read_en_n, slave_addr_strap_pins};
    nx.sy2 = st.sy1;
    nx.ln1 = {two_wire_serial_clock_i, serial_data_i};
    nx.ln2 = st.ln1;
    nx.ln3 = st.ln2;
    nx.os1 = recovered_clock_oscillator_div;
    nx.os2 = st.os1;
    nx.os3 = st.os2;
    nx.drv_lvl = 1'b0;
    case (st.top)
      T_BOOT: begin
        nx.boot = st.boot + 2'h1;
        if (st.boot == 2'h3) begin
          nx.mode_slave = st.sy2[`SY_MODE];
          if (st.sy2[`SY_MODE] && st.sy2[`SY_RDN]) begin
            nx.addr = `TEST_ADDR7;
          end else begin
            nx.addr = `BASE_ADDR7 + {3'h0, st.sy2[3:0]};
          end
          nx.top = st.sy2[`SY_MODE] ? T_SLAVE : T_WAIT;
          nx.done_n = ~st.sy2[`SY_MODE];
        end
      end
      T_WAIT: begin
        if (!st.sy2[`SY_RDN]) begin
          nx.top = T_LOAD;
          nx.mst = M_START;
          nx.step = 3'h0;
          nx.ph = 2'h0;
          nx.qc = 4'h0;
          nx.nbyte = 6'h00;
          nx.nack = 1'b0;
        end
      end
      T_LOAD: begin
        nx.qc = tick ? 4'h0 : st.qc + 4'h1;
        if (tick) begin
          nx.ph = st.ph + 2'h1;
          case (st.ph)
            2'h0: nx.scl_oe = 1'b0;
            2'h1: begin
              if (st.mst == M_START) nx.sda_oe = 1'b1;
              else if (st.mst == M_STOP) nx.sda_oe = 1'b0;
            end
            2'h2: begin
              if (st.mst != M_STOP) nx.scl_oe = 1'b1;
              if (st.mst == M_SEND && st.bitn == 4'h8) nx.nack = st.nack | st.ln2[0];
              if (st.mst == M_RECV && st.bitn != 4'h8) nx.sh = {st.sh[6:0], st.ln2[0]};
            end
            default: begin
              if ((st.mst == M_SEND || st.mst == M_RECV) && st.bitn != 4'h8) begin
                nx.bitn = st.bitn + 4'h1;
                if (st.mst == M_SEND) begin
                  nx.sh = {st.sh[6:0], 1'b0};
                  nx.sda_oe = (st.bitn == 4'h7) ? 1'b0 : ~st.sh[6];
                end else begin
                  if (st.bitn == 4'h7) nx.regs[st.nbyte[4:3]][st.nbyte[2:0]] = st.sh;
                  nx.sda_oe = (st.bitn == 4'h7) && (st.nbyte != `EE_LAST_BYTE);
                end
              end else if (st.mst == M_RECV && st.nbyte != `EE_LAST_BYTE) begin
                nx.nbyte = st.nbyte + 6'h01;
                nx.bitn = 4'h0;
                nx.sda_oe = 1'b0;
              end else if (st.mst == M_STOP) begin
                nx.sda_oe = 1'b0;
                nx.scl_oe = 1'b0;
                nx.step = 3'h0;
                nx.mst = M_START;
                nx.nbyte = 6'h00;
                nx.nack = 1'b0;
                if (!st.nack) begin
                  nx.top = T_SLAVE;
                  nx.done_n = 1'b0;
                end
              end else begin
                nx.step = st.nack ? 3'h6 : st.step + 3'h1;
                nx.mst = seg_kind(nx.step);
                nx.sh = seg_byte(nx.step);
                nx.bitn = 4'h0;
                nx.sda_oe = (nx.mst == M_STOP) | ((nx.mst == M_SEND) & ~nx.sh[7]);
              end
            end
          endcase
        end
      end
      T_SLAVE: begin
        if (start_c) begin
          nx.slv = S_ADDR;
          nx.cnt = 4'hF; // Clock fall after START wraps to bit zero
          nx.sda_oe = 1'b0;
        end else if (stop_c) begin
          nx.slv = S_IDLE;
          nx.sda_oe = 1'b0;
        end else if (st.slv != S_IDLE) begin
          if (rise) begin
            if (st.cnt != 4'h8) begin
              nx.sh = {st.sh[6:0], st.ln2[0]};
            end else if (st.slv == S_RD && !st.sda_oe) begin
              if (st.ln2[0]) begin
                nx.slv = S_IDLE;
              end else begin
                nx.ptr = st.ptr + 8'h01;
                nx.tx = rd_byte(st, st.ptr + 8'h01);
              end
            end
          end
          if (fall) begin
            nx.cnt = (st.cnt == 4'h8) ? 4'h0 : st.cnt + 4'h1;
            if (st.cnt == 4'h7) begin
              nx.sda_oe = 1'b1;
              case (st.slv)
                S_ADDR: begin
                  if (st.sh[7:1] == st.addr) begin
                    nx.slv = st.sh[0] ? S_RD : S_REG;
                    nx.tx = rd_byte(st, st.ptr);
                  end else begin
                    nx.slv = S_IDLE;
                    nx.sda_oe = 1'b0;
                  end
                end
                S_REG: begin
                  nx.ptr = st.sh;
                  nx.slv = S_WR;
                end
                S_WR: begin
                  sl = slot_of(st.ptr);
                  if (st.ptr == `OFS_CHAN_SEL) nx.chsel = st.sh[1:0];
                  else if (sl[3]) nx.regs[st.chsel][sl[2:0]] = st.sh;
                  nx.ptr = st.ptr + 8'h01;
                end
                default: nx.sda_oe = 1'b0;
              endcase
            end else if (st.cnt == 4'h8) begin
              nx.sda_oe = (st.slv == S_RD) & ~st.tx[7];
            end else if (st.slv == S_RD) begin
              nx.sda_oe = ~st.tx[6];
              nx.tx = {st.tx[6:0], 1'b0};
            end
          end
        end
      end
      default: nx.top = T_BOOT;
    endcase
    nx.win = (st.win == 16'(MEAS_WINDOW_CYC - 1)) ? 16'h0000 : st.win + 16'h0001;
    for (int c = 0; c < `NUM_CHAN; c++) begin
      nx.auto_eth[c] = (st.regs[c][`SLOT_RATE][7:4] == `RATE_AUTO_ETH);
      if (st.win == 16'(MEAS_WINDOW_CYC - 1)) begin
        nx.lock_ok[c] = fmatch[c];
        nx.fcnt[c] = {15'h0000, st.os2[c] & ~st.os3[c]};
      end else begin
        nx.fcnt[c] = st.fcnt[c] + {15'h0000, st.os2[c] & ~st.os3[c]};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
      st.done_n <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  assign two_wire_serial_clock_o  = st.drv_lvl;
  assign two_wire_serial_clock_oe = st.scl_oe;
  assign serial_data_o            = st.drv_lvl;
  assign serial_data_oe           = st.sda_oe;
  assign done_n                   = st.done_n;
  assign slave_addr               = st.addr;
  assign channel_config           = st.regs;
  assign dual_rate_auto           = st.auto_eth;
  assign freq_lock_ok             = st.lock_ok;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  done_hold_a: assert property (st.top != T_SLAVE |-> st.done_n)
    else $error("done went low before load finished");
  load_gate_a: assert property (st.top == T_WAIT ##1 st.top == T_LOAD |-> !$past(st.sy2[`SY_RDN]))
    else $error("load started without read enable low");
  wait_hold_a: assert property (st.top == T_WAIT && st.sy2[`SY_RDN] |=> st.top == T_WAIT)
    else $error("left wait while read enable high");
  done_fall_a: assert property ($fell(st.done_n) && st.mode_slave == 1'b0 |-> $past(st.mst) == M_STOP)
    else $error("done fell outside stop segment");
  slave_after_a: assert property ($fell(st.done_n) |-> st.top == T_SLAVE && !st.scl_oe && !st.sda_oe)
    else $error("bus not released after load");
  addr_range_a: assert property (st.top != T_BOOT |-> st.addr >= `BASE_ADDR7 && st.addr <= `MAX_ADDR7)
    else $error("slave address out of range");
  strap_latch_a: assert property (st.top == T_BOOT && st.boot == 2'h3 && !(st.sy2[`SY_MODE] && st.sy2[`SY_RDN])
    |=> st.addr == `BASE_ADDR7 + {3'h0, $past(st.sy2[3:0])})
    else $error("strap address not latched");
  test_addr_a: assert property (st.top == T_BOOT && st.boot == 2'h3 && st.sy2[`SY_MODE] && st.sy2[`SY_RDN]
    |=> st.addr == `TEST_ADDR7)
    else $error("test address not used");
  addr_stable_a: assert property (st.top != T_BOOT |=> $stable(st.addr))
    else $error("slave address changed after latch");
  no_slave_a: assert property (st.top != T_SLAVE |-> st.slv == S_IDLE)
    else $error("slave active during load");
  dir_sel_a: assert property (st.slv == S_ADDR && fall && st.cnt == 4'h7 && st.sh[7:1] == st.addr && !start_c
    && !stop_c |=> st.slv == ($past(st.sh[0]) ? S_RD : S_REG) && st.sda_oe)
    else $error("direction bit not honoured");
  auto_mode_a: assert property (st.regs[0][`SLOT_RATE][7:4] == `RATE_AUTO_ETH ##1 $stable(st.regs[0])
    |-> st.auto_eth[0])
    else $error("dual Ethernet mode not selected");

  load_done_c: cover property ($fell(st.done_n) && !st.mode_slave);
  slave_write_c: cover property (st.slv == S_WR && fall && st.cnt == 4'h7);
  slave_read_c: cover property (st.slv == S_RD && rise && st.cnt == 4'h8 && !st.ln2[0]);
  test_addr_c: cover property (st.top == T_SLAVE && st.addr == `TEST_ADDR7 && st.mode_slave);

endmodule // smbus_config_boot

// File: eeprom_model.sv
`timescale 1ns/1ps

module eeprom_model #(
  parameter int NAK_FIRST = 1
) (
  input  wire logic scl,
  input  wire logic sda,
  output logic      sda_oe
);
  logic [7:0] mem [32];
  logic [7:0] sh;
  logic [4:0] ptr;
  int         cnt;
  int         ph;
  int         naks;

  initial begin
    sda_oe = 1'b0;
    ph = 0;
    cnt = 0;
    ptr = 5'h00;
    sh = 8'h00;
    naks = NAK_FIRST;
    for (int i = 0; i < 32; i++) begin
      mem[i] = 8'hA0 + 8'(i);
    end
    mem[0] = 8'hF6;
    mem[1] = 8'h08;
    mem[2] = 8'h00;
    mem[5] = 8'h22;
    mem[8] = 8'h26;
    mem[9] = 8'h40;
    mem[10] = 8'h00;
  end

  // Start or repeated start
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      ph = 1;
      cnt = -1;
    end
  end

  // Stop
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      ph = 0;
    end
  end

  always @(posedge scl) begin
    if (ph == 3 && cnt == 8) begin
      if (sda === 1'b1) ph = 0;
      else ptr = ptr + 5'h01;
    end else if (ph != 0 && cnt < 8) begin
      sh = {sh[6:0], sda};
    end
  end

  // Data changes only while the clock is low; released line floats high
  always @(negedge scl) begin : drive_edge
    logic oe_v;
    oe_v = 1'b0;
    if (ph != 0) begin
      cnt = (cnt == 8) ? 0 : cnt + 1;
      if (ph == 4) ph = 3;
      if (cnt == 8 && ph == 1) begin
        if (sh[7:1] == 7'h50 && naks == 0) begin
          oe_v = 1'b1;
          ph = sh[0] ? 4 : 2;
        end else begin
          if (sh[7:1] == 7'h50) naks = naks - 1;
          ph = 0;
        end
      end else if (cnt == 8 && ph == 2) begin
        oe_v = 1'b1;
        ptr = sh[4:0];
        ph = 5;
      end else if (ph == 3 && cnt < 8) begin
        oe_v = ~mem[ptr][7 - cnt];
      end
    end
    sda_oe = oe_v;
  end
endmodule // eeprom_model

// File: tb.sv
`timescale 1ns/1ps
`include "smbus_boot_regs.svh"

module tb;
  import smbus_boot_pkg::*;
  logic       clk, rst, mode, ren_n, osc, scl_pull, sda_pull;
  logic       scl_o, scl_oe, sda_o, sda_oe, ee_oe, done_n;
  logic [3:0] strap, ado, lock;
  logic [6:0] addr;
  logic [`NUM_CHAN*`CHAN_SLOTS*8-1:0] cfg;
  wire        scl = ~(scl_oe | scl_pull);
  wire        sda = ~(sda_oe | sda_pull | ee_oe);
  int         n_errors = 0;
  int         comparisons = 0;

  smbus_config_boot #(.MEAS_WINDOW_CYC(64)) smbus_config_boot_inst (
    .clk(clk), .rst(rst), .bus_mode_select(mode), .read_en_n(ren_n), .slave_addr_strap_pins(strap),
    .two_wire_serial_clock_i(scl), .two_wire_serial_clock_o(scl_o), .two_wire_serial_clock_oe(scl_oe),
    .serial_data_i(sda), .serial_data_o(sda_o), .serial_data_oe(sda_oe),
    .recovered_clock_oscillator_div({4{osc}}), .done_n(done_n), .slave_addr(addr),
    .channel_config(cfg), .dual_rate_auto(ado), .freq_lock_ok(lock));
  eeprom_model eeprom_model_inst (.scl(scl), .sda(sda), .sda_oe(ee_oe));

  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  initial begin
    osc = 1'b0;
    #7;
    forever #100 osc = ~osc;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic final_report;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic q;
    repeat (2) @(negedge clk);
  endtask

  task automatic boot(input logic m, input logic r, input logic [3:0] s);
    @(negedge clk);
    rst = 1'b1;
    mode = m;
    ren_n = r;
    strap = s;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
  endtask

  // One bit, 8 clocks: 6 low, 2 high
  task automatic bit_io(input logic b, output logic r);
    q;
    sda_pull = ~b;
    q;
    q;
    scl_pull = 1'b0;
    q;
    r = sda;
    scl_pull = 1'b1;
  endtask

  task automatic start_c;
    sda_pull = 1'b0;
    repeat (3) q;
    scl_pull = 1'b0;
    q;
    sda_pull = 1'b1;
    q;
    scl_pull = 1'b1;
  endtask

  task automatic stop_c;
    sda_pull = 1'b1;
    repeat (2) q;
    scl_pull = 1'b0;
    q;
    sda_pull = 1'b0;
    q;
  endtask

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask

  task automatic xfer_wr(input logic [6:0] a7, input logic [7:0] ofs, input logic [7:0] dat, output logic ok);
    logic a0, a1, a2;
    start_c;
    wr_byte({a7, 1'b0}, a0);
    wr_byte(ofs, a1);
    wr_byte(dat, a2);
    stop_c;
    ok = a0 & a1 & a2;
  endtask

  task automatic xfer_rd(input logic [6:0] a7, input logic [7:0] ofs, output logic [7:0] d, output logic [7:0] d2);
    logic a;
    start_c;
    wr_byte({a7, 1'b0}, a);
    wr_byte(ofs, a);
    start_c;
    wr_byte({a7, 1'b1}, a);
    rd_byte(1'b0, d);
    rd_byte(1'b1, d2);
    stop_c;
  endtask

  task automatic test_address;
    logic ok;
    boot(1'b1, 1'b1, 4'hA);
    check({1'b0, addr}, 8'h18, "test addr");
    check({7'h0, done_n}, 8'h00, "slave done");
    xfer_wr(7'h18, 8'h2D, 8'h3C, ok);
    check({7'h0, ok}, 8'h01, "test addr ack");
    check(cfg[48 +: 8], 8'h3C, "swing");
  endtask

  task automatic strap_sweep;
    for (int s = 0; s < 16; s++) begin
      boot(1'b1, 1'b0, 4'(s));
      check({1'b0, addr}, 8'h18 + 8'(s), "strap addr");
    end
    strap = 4'h0;
    repeat (20) @(negedge clk);
    check({1'b0, addr}, 8'h27, "addr held");
  endtask

  task automatic slave_access;
    logic ok;
    logic [7:0] d;
    logic [7:0] d2;
    boot(1'b1, 1'b0, 4'h5);
    xfer_wr(7'h1D, 8'hFF, 8'h02, ok);
    xfer_wr(7'h1D, 8'h2F, 8'hF6, ok);
    check({7'h0, ok}, 8'h01, "write ack");
    repeat (4) @(negedge clk);
    check(cfg[128 +: 8], 8'hF6, "chan 2 rate");
    check(cfg[0 +: 8], 8'h00, "chan 0 rate");
    check({4'h0, ado}, 8'h04, "dual mode");
    xfer_wr(7'h1D, 8'h64, 8'hA7, ok);
    check(cfg[168 +: 8], 8'hA7, "tolerance");
    xfer_wr(7'h1D, 8'h60, 8'h00, ok);
    xfer_wr(7'h1D, 8'h61, 8'hB2, ok);
    check(cfg[144 +: 8], 8'hB2, "count high");
    xfer_rd(7'h1D, 8'h2F, d, d2);
    check(d, 8'hF6, "read back");
    check(d2, 8'h00, "unmapped read");
    xfer_rd(7'h1D, 8'h60, d, d2);
    check(d, 8'h00, "count low read");
    check(d2, 8'hB2, "count high read");
    xfer_wr(7'h1C, 8'h2F, 8'h16, ok);
    check({7'h0, ok}, 8'h00, "foreign addr");
    check(cfg[128 +: 8], 8'hF6, "no write");
  endtask

  task automatic master_load;
    logic ok;
    int n;
    boot(1'b0, 1'b1, 4'h3);
    n = 0;
    repeat (300) begin
      @(negedge clk);
      if (scl_oe !== 1'b0 || sda_oe !== 1'b0) n++;
    end
    check({7'h0, n != 0}, 8'h00, "bus idle");
    check({7'h0, done_n}, 8'h01, "done high");
    xfer_wr(7'h1B, 8'h15, 8'hC3, ok);
    check({7'h0, ok}, 8'h00, "no slave before load");
    check({7'h0, done_n}, 8'h01, "done held");
    ren_n = 1'b0;
    n = 0;
    while (done_n !== 1'b0 && n < 8000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 8000) begin
      n_errors++;
      $display("BAD %0t load timeout", $time);
      final_report;
    end
    for (int k = 0; k < 32; k++) check(cfg[k*8 +: 8], eeprom_model_inst.mem[k], "image");
    check({1'b0, addr}, 8'h1B, "boot addr");
    check({6'h0, scl_o, sda_o}, 8'h00, "drive level");
    check({4'h0, ado}, 8'h01, "loaded dual");
    repeat (200) @(negedge clk);
    check({6'h0, lock[1:0]}, 8'h01, "lock check");
    xfer_wr(7'h1B, 8'h15, 8'h5A, ok);
    check({7'h0, ok}, 8'h01, "slave after load");
    check(cfg[56 +: 8], 8'h5A, "deemph write");
    check({7'h0, scl_oe}, 8'h00, "clock released");
  endtask

  initial begin
    rst = 1'b1;
    mode = 1'b1;
    ren_n = 1'b0;
    strap = 4'h0;
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    test_address;
    strap_sweep;
    slave_access;
    master_load;
    final_report;
  end
endmodule // tb
